// ==== rtl/mbc_defines.vh ====
// register offsets, field positions, mode codes and key values of the mode-entry block
// assumes inclusion by bare name from the design file
`ifndef MBC_DEFINES_VH
`define MBC_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MBC_OFS_STATUS 8'h00
`define MBC_OFS_TRANS 8'h04
`define MBC_OFS_ALLOW 8'h08
`define MBC_OFS_INVAL 8'h0C
`define MBC_OFS_CTL_BASE 8'h10
`define MBC_OFS_VEC_BASE 8'h30
`define MBC_OFS_IDX_LSB 2
`define MBC_OFS_IDX_MSB 4
`define MBC_BANK_MSB 7
`define MBC_BANK_LSB 4
`define MBC_BANK_CTL 4'h1
`define MBC_BANK_VEC 4'h3
// ----------------------------------------------------------------
// chip mode codes
// ----------------------------------------------------------------
`define MBC_MODE_RESET 4'h0
`define MBC_MODE_TEST 4'h1
`define MBC_MODE_SAFE 4'h2
`define MBC_MODE_DEFAULT_RUN_MODE 4'h3
`define MBC_MODE_RUN0 4'h4
`define MBC_MODE_RUN3 4'h7
`define MBC_MODE_HALT 4'h8
`define MBC_MODE_STOP 4'hA
`define MBC_MODE_SLEEP 4'hD
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define MBC_KEY 16'h5AF0
`define MBC_KEY_INV 16'hA50F
`define MBC_TRANS_MODE_MSB 31
`define MBC_TRANS_MODE_LSB 28
`define MBC_KEY_MSB 15
`define MBC_KEY_LSB 0
`define MBC_ALLOW_MSB 15
`define MBC_ALLOW_NONE 16'h0000
`define MBC_INVAL_BIT 0
`define MBC_VEC_RST 32'h00000000
`define MBC_VEC_MSB 29
`define MBC_RMC_BIT 31
`define MBC_ST_PEND_BIT 27
`define MBC_ST_MODE_MSB 31
`define MBC_ST_MODE_LSB 28
`define MBC_ALLOW_RST 16'hFFFF
`define MBC_CTL_BOOT_RST 16'h00FE
`define MBC_CTL_RST 16'h0000
`define MBC_ALLOW_RESERVED 16'h0001
`define MBC_TRANS_CYC 4'h4
`endif

// ==== rtl/mbc_mode_entry.v ====
// mode-entry block: per-core run control, boot vectors, keyed mode transitions
// assumes a single 40 MHz clock and a synchronous register port from the boot cpu
`timescale 1ns/100ps
`include "mbc_defines.vh"
module mbc_mode_entry (
  SYS_CLK,
  SYS_RST,
  REG_ADDR,
  REG_WDATA,
  REG_WR,
  REG_RD,
  REG_RDATA,
  FW_BOOT,
  FW_DONE,
  FW_CORE_MASK,
  CORE_CLK_EN,
  CORE_RST,
  CORE_VEC0,
  CORE_VEC1,
  CORE_VEC2,
  CORE_VEC3
);
  input wire SYS_CLK;
  input wire SYS_RST;
  input wire [7:0] REG_ADDR;
  input wire [31:0] REG_WDATA;
  input wire REG_WR;
  input wire REG_RD;
  output reg [31:0] REG_RDATA;
  input wire FW_BOOT;
  input wire FW_DONE;
  input wire [3:0] FW_CORE_MASK;
  output wire [3:0] CORE_CLK_EN;
  output reg [3:0] CORE_RST;
  output wire [29:0] CORE_VEC0;
  output wire [29:0] CORE_VEC1;
  output wire [29:0] CORE_VEC2;
  output wire [29:0] CORE_VEC3;

  localparam ST_IDLE = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_TRANS = 2'b10;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [1:0] st_r;
  reg [3:0] mode_r;
  reg [3:0] target_r;
  reg [3:0] arm_mode_r;
  reg [3:0] cnt_r;
  reg [15:0] allow_r;
  reg inval_r;
  reg released_r;
  reg mode_chg_r;
  reg [15:0] ctl_r [0:3];
  reg [31:0] vec_r [0:3];

  // ----------------------------------------------------------------
  // register address decode
  // ----------------------------------------------------------------
  wire sel_status;
  wire sel_trans;
  wire sel_allow;
  wire sel_inval;
  wire in_ctl;
  wire in_vec;
  wire [1:0] idx;
  // fixed registers match the whole byte address
  assign sel_status = (REG_ADDR == `MBC_OFS_STATUS);
  assign sel_trans = (REG_ADDR == `MBC_OFS_TRANS);
  assign sel_allow = (REG_ADDR == `MBC_OFS_ALLOW);
  assign sel_inval = (REG_ADDR == `MBC_OFS_INVAL);
  // per-core banks match the upper nibble, the word index picks the core
  assign in_ctl = (REG_ADDR[`MBC_BANK_MSB:`MBC_BANK_LSB] == `MBC_BANK_CTL);
  assign in_vec = (REG_ADDR[`MBC_BANK_MSB:`MBC_BANK_LSB] == `MBC_BANK_VEC);
  assign idx = REG_ADDR[`MBC_OFS_IDX_MSB-1:`MBC_OFS_IDX_LSB];

  // ----------------------------------------------------------------
  // write decode and request fields
  // ----------------------------------------------------------------
  wire wr_trans;
  wire wr_allow;
  wire wr_inval;
  wire [3:0] wr_mode;
  wire [15:0] wr_key;
  wire key_fwd;
  wire key_inv;
  wire allow_bad;
  // write strobe qualified by the selected register
  assign wr_trans = REG_WR && sel_trans;
  assign wr_allow = REG_WR && sel_allow;
  assign wr_inval = REG_WR && sel_inval;
  // mode and key fields of a transition write
  assign wr_mode = REG_WDATA[`MBC_TRANS_MODE_MSB:`MBC_TRANS_MODE_LSB];
  assign wr_key = REG_WDATA[`MBC_KEY_MSB:`MBC_KEY_LSB];
  assign key_fwd = wr_trans && (wr_key == `MBC_KEY);
  assign key_inv = wr_trans && (wr_key == `MBC_KEY_INV);
  // a mask that drops the current mode or allows the reset mode is refused
  assign allow_bad = !REG_WDATA[mode_r] ||
    ((REG_WDATA[`MBC_ALLOW_MSB:`MBC_KEY_LSB] & `MBC_ALLOW_RESERVED) != `MBC_ALLOW_NONE);

  // ----------------------------------------------------------------
  // mode classes
  // ----------------------------------------------------------------
  wire low_power;
  wire target_ok;
  wire done;
  wire pending;
  // halt, stop, sleep and reset modes freeze every core whatever its run control says
  assign low_power = (mode_r == `MBC_MODE_HALT) || (mode_r == `MBC_MODE_STOP) ||
    (mode_r == `MBC_MODE_SLEEP) || (mode_r == `MBC_MODE_RESET);
  // target must be allowed in the mask and must not be the reset mode
  assign target_ok = allow_r[wr_mode] && (wr_mode != `MBC_MODE_RESET);
  // last cycle of the fixed-length transition
  assign done = (st_r == ST_TRANS) && (cnt_r == `MBC_TRANS_CYC);
  // status flag while the transition runs
  assign pending = (st_r == ST_TRANS);

  // ----------------------------------------------------------------
  // keyed transition sequencer
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      mode_r <= `MBC_MODE_DEFAULT_RUN_MODE;
      target_r <= `MBC_MODE_DEFAULT_RUN_MODE;
      arm_mode_r <= `MBC_MODE_RESET;
      cnt_r <= 4'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // a key write arms the sequencer with its mode
          if (key_fwd) begin
            st_r <= ST_ARMED;
            arm_mode_r <= wr_mode;
          end
        end
        ST_ARMED: begin
          if (wr_trans) begin
            // same mode as current is fine, only the mask and the reset-mode rule are checked
            if (key_inv && wr_mode == arm_mode_r && target_ok) begin
              st_r <= ST_TRANS;
              target_r <= wr_mode;
              cnt_r <= 4'h0;
            end else begin
              st_r <= ST_IDLE;
            end
          end else if (REG_WR) begin
            st_r <= ST_IDLE;
          end
        end
        ST_TRANS: begin
          // count out the fixed transition length
          cnt_r <= cnt_r + 4'h1;
          if (done) begin
            st_r <= ST_IDLE;
            mode_r <= target_r;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode-change strobe, one cycle after a transition completes
  // ----------------------------------------------------------------
  // cores pulsed into reset at completion are let go on this cycle
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_chg_r <= 1'b0;
    end else begin
      mode_chg_r <= done;
    end
  end

  // ----------------------------------------------------------------
  // mode-allow mask
  // ----------------------------------------------------------------
  // a refused mask leaves the old one in place
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      allow_r <= `MBC_ALLOW_RST;
    end else if (wr_allow && !allow_bad) begin
      allow_r <= REG_WDATA[`MBC_ALLOW_MSB:`MBC_KEY_LSB];
    end
  end

  // ----------------------------------------------------------------
  // invalid-configuration flag
  // ----------------------------------------------------------------
  // a request refused by the mask or the reset-mode rule, or a refused mask, sets the flag, and the set wins over a clear
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      inval_r <= 1'b0;
    end else if ((st_r == ST_ARMED) && key_inv && (wr_mode == arm_mode_r) && !target_ok) begin
      inval_r <= 1'b1;
    end else if (wr_allow && allow_bad) begin
      inval_r <= 1'b1;
    end else if (wr_inval && REG_WDATA[`MBC_INVAL_BIT]) begin
      inval_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-core run control, vectors, resets (index 0..3 maps to slots 0..3)
  // ----------------------------------------------------------------
  // one slice per core: run control, boot vector and reset hold
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : core
      always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          ctl_r[g] <= (g == 0) ? `MBC_CTL_BOOT_RST : `MBC_CTL_RST;
          vec_r[g] <= `MBC_VEC_RST;
          CORE_RST[g] <= 1'b1;
        end else begin
          // run-control word, one bit per chip mode
          if (REG_WR && in_ctl && idx == g) begin
            ctl_r[g] <= REG_WDATA[`MBC_ALLOW_MSB:`MBC_KEY_LSB];
          end
          // boot vector, bit 30 is kept clear
          if (REG_WR && in_vec && idx == g) begin
            vec_r[g] <= {REG_WDATA[`MBC_RMC_BIT], 1'b0, REG_WDATA[`MBC_VEC_MSB:0]};
          end
          // first release after reset, then reset-on-mode-change pulses, which also let go of cores still held since reset
          if (!released_r && !FW_BOOT && g == 0) begin
            CORE_RST[g] <= 1'b0;
          end else if (!released_r && FW_BOOT && FW_DONE && FW_CORE_MASK[g]) begin
            CORE_RST[g] <= 1'b0;
          end else if (done && vec_r[g][`MBC_RMC_BIT] && ctl_r[g][target_r]) begin
            CORE_RST[g] <= 1'b1;
          end else if (mode_chg_r && CORE_RST[g] && vec_r[g][`MBC_RMC_BIT] && ctl_r[g][mode_r]) begin
            CORE_RST[g] <= 1'b0; // released at its new vector
          end
        end
      end
      assign CORE_CLK_EN[g] = ctl_r[g][mode_r] && !low_power;
    end
  endgenerate

  // start addresses seen by the cores, flag bits stripped
  assign CORE_VEC0 = vec_r[0][`MBC_VEC_MSB:0];
  assign CORE_VEC1 = vec_r[1][`MBC_VEC_MSB:0];
  assign CORE_VEC2 = vec_r[2][`MBC_VEC_MSB:0];
  assign CORE_VEC3 = vec_r[3][`MBC_VEC_MSB:0];

  // ----------------------------------------------------------------
  // initial release latch
  // ----------------------------------------------------------------
  // remembers that the reset-exit release has been made
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      released_r <= 1'b0;
    end else if (!FW_BOOT || FW_DONE) begin
      released_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      // unmapped addresses read as zero
      if (sel_status)
        REG_RDATA <= {mode_r, pending, 27'h0000000};
      else if (sel_trans)
        REG_RDATA <= {target_r, 28'h0000000};
      else if (sel_allow)
        REG_RDATA <= {16'h0000, allow_r};
      else if (sel_inval)
        REG_RDATA <= {31'h00000000, inval_r};
      else if (in_ctl)
        REG_RDATA <= {16'h0000, ctl_r[idx]};
      else if (in_vec)
        REG_RDATA <= vec_r[idx];
      else
        REG_RDATA <= 32'h00000000;
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end
endmodule

// ==== test/mbc_mode_entry_chk.sv ====
// assertion checker for the mode-entry block
// assumes binding onto mbc_mode_entry, seeing its ports only
`timescale 1ns/100ps
module mbc_mode_entry_chk (
  input logic SYS_CLK,
  input logic SYS_RST,
  input logic [7:0] REG_ADDR,
  input logic [31:0] REG_WDATA,
  input logic REG_WR,
  input logic REG_RD,
  input logic [31:0] REG_RDATA,
  input logic FW_BOOT,
  input logic FW_DONE,
  input logic [3:0] FW_CORE_MASK,
  input logic [3:0] CORE_CLK_EN,
  input logic [3:0] CORE_RST,
  input logic [29:0] CORE_VEC1
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic [3:0] cnt_r;
  // cycles since the last inverted-key write, saturating at 15
  always @(posedge SYS_CLK) begin
    if (SYS_RST)
      cnt_r <= 4'hF;
    else if (REG_WR && REG_ADDR == 8'h04 && REG_WDATA[15:0] == 16'hA50F)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not idle");
  a_vec_bit30: assert property (REG_RD && REG_ADDR[7:4] == 4'h3 |=> !REG_RDATA[30])
    else $error("vector bit 30 set");
  a_vec_write: assert property (REG_WR && REG_ADDR == 8'h34 |=> CORE_VEC1 == $past(REG_WDATA[29:0]))
    else $error("vector not updated");
  a_lowpwr_gated: assert property (REG_RD && REG_ADDR == 8'h00 ##1 !REG_RDATA[27] &&
    REG_RDATA[31:28] inside {4'h8, 4'hA, 4'hD} |-> CORE_CLK_EN == 4'h0)
    else $error("clock on in low power");
  a_boot_default: assert property ($fell(SYS_RST) |-> CORE_CLK_EN == 4'h1)
    else $error("boot clock default");
  a_solo_boot: assert property ($fell(SYS_RST) && !FW_BOOT |-> ##[1:3] CORE_RST == 4'hE)
    else $error("boot core release");
  a_fw_release: assert property (FW_BOOT && FW_DONE |=> (CORE_RST & $past(FW_CORE_MASK)) == 4'h0)
    else $error("firmware release");
  a_rmc_pulse: assert property ($rose(CORE_RST[1]) |=> !CORE_RST[1])
    else $error("core reset not a pulse");
  a_rmc_timing: assert property ($rose(CORE_RST[1]) |-> cnt_r == 4'h5)
    else $error("core reset timing");
endmodule
bind mbc_mode_entry mbc_mode_entry_chk i_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FW_BOOT(FW_BOOT),
  .FW_DONE(FW_DONE), .FW_CORE_MASK(FW_CORE_MASK), .CORE_CLK_EN(CORE_CLK_EN), .CORE_RST(CORE_RST),
  .CORE_VEC1(CORE_VEC1));

// ==== test/mbc_mode_entry_tb.sv ====
// self-checking bench for the mode-entry block
// assumes rtl/ on the include path for the register constants
`timescale 1ns/100ps
`include "mbc_defines.vh"
module mbc_mode_entry_tb;
  logic SYS_CLK = 1'h0, SYS_RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, FW_BOOT = 1'h0, FW_DONE = 1'h0;
  logic [7:0] REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic [3:0] FW_CORE_MASK = 4'h5, CORE_CLK_EN, CORE_RST;
  logic [29:0] CORE_VEC1;
  int fails = 0, compares = 0;
  // address, write data, read-back value
  logic [71:0] rows [6] = '{{8'h34, 32'hC0000100, 32'h80000100}, {8'h14, 32'h8, 32'h8},
    {8'h3C, 32'h3FFFFFFF, 32'h3FFFFFFF}, {8'h08, 32'hFFFE, 32'hFFFE}, {8'h08, 32'hFFF7, 32'hFFFE},
    {8'hFC, 32'hFFFFFFFF, 32'h0}};
  always #12.5 SYS_CLK = ~SYS_CLK;
  mbc_mode_entry i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FW_BOOT(FW_BOOT), .FW_DONE(FW_DONE),
    .FW_CORE_MASK(FW_CORE_MASK), .CORE_CLK_EN(CORE_CLK_EN), .CORE_RST(CORE_RST), .CORE_VEC0(),
    .CORE_VEC1(CORE_VEC1), .CORE_VEC2(), .CORE_VEC3());
  // -----------------------------------------------------------
  // bus tasks and checks
  // -----------------------------------------------------------
  task automatic conclude;
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge SYS_CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= w;
    @(posedge SYS_CLK);
    REG_WR <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'h0;
    #1 d = REG_RDATA;
  endtask
  // keyed request: key write, then inverted-key write
  task automatic trans(input logic [3:0] m);
    wr(8'h04, {m, 12'h0, `MBC_KEY});
    wr(8'h04, {m, 12'h0, `MBC_KEY_INV});
  endtask
  // poll status until the pending flag drops, bounded
  task automatic settle;
    for (int i = 0; i < 20; i++) begin
      rd(8'h00);
      if (d[27] === 1'h0) return;
    end
    chk("pending timeout", d[27], 1'h0);
    conclude;
  endtask
  task automatic rst(input logic fw);
    SYS_RST <= 1'h1;
    FW_BOOT <= fw;
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= 1'h0;
  endtask
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    rst(1'h0);
    repeat (4) @(posedge SYS_CLK);
    #1 chk("core reset", CORE_RST, 4'hE);
    chk("clock enable", CORE_CLK_EN, 4'h1);
    rd(8'h00);
    chk("status", d[31:27], 5'h06);
    rd(8'h10);
    chk("boot core ctl", d, 32'hFE);
    rd(8'h08);
    chk("allow mask", d, 32'hFFFF);
    foreach (rows[i]) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64]);
      chk("register", d, rows[i][31:0]);
    end
    rd(8'h0C);
    chk("invalid flag", d[0], 1'h1);
    wr(8'h0C, 32'h1);
    rd(8'h0C);
    chk("invalid clear", d[0], 1'h0);
    // same-mode request starts the second core
    trans(`MBC_MODE_DEFAULT_RUN_MODE);
    rd(8'h00);
    chk("pending", d[27], 1'h1);
    settle;
    chk("mode", d[31:28], `MBC_MODE_DEFAULT_RUN_MODE);
    chk("clocks", CORE_CLK_EN, 4'h3);
    chk("vector", CORE_VEC1, 30'h100);
    chk("core started", CORE_RST, 4'hC);
    // a second same-mode request pulses the running core through reset
    trans(`MBC_MODE_DEFAULT_RUN_MODE);
    settle;
    chk("core restarted", CORE_RST, 4'hC);
    // bad first key, then a key broken by another write
    for (int i = 0; i < 2; i++) begin
      wr(8'h04, {`MBC_MODE_RUN0, 12'h0, i ? `MBC_KEY : 16'h5AF1});
      if (i) wr(8'h10, 32'hFE);
      wr(8'h04, {`MBC_MODE_RUN0, 12'h0, `MBC_KEY_INV});
      rd(8'h00);
      chk("ignored request", d[31:27], 5'h06);
    end
    trans(`MBC_MODE_HALT);
    settle;
    chk("halt mode", d[31:28], `MBC_MODE_HALT);
    chk("halt clocks", CORE_CLK_EN, 4'h0);
    rst(1'h1);
    repeat (3) @(posedge SYS_CLK);
    #1 chk("held cores", CORE_RST, 4'hF);
    @(posedge SYS_CLK);
    FW_DONE <= 1'h1;
    @(posedge SYS_CLK);
    FW_DONE <= 1'h0;
    #1 chk("released cores", CORE_RST, 4'hA);
    conclude;
  end
endmodule
